// ### rtl/dtfm_device.sv
// DRAM side: training control and per set point DQ reference registers
// Behaviour
// R1: Bit 0 enters training; echo CA when CKE low
// R2: Controller raises CKE before clearing training bit
// R3: Bit 1 enables read preamble training
// R4: Bit 2 outputs active set point references
// R5: Bit 3 selects fast reference settling
// R6: Option zero maps codes 001/010 to 011
// R7: Option applies only when configuration bit set
// R8: Controller follows status; self refresh independent
// R9: Bit 5 disables masking; masked writes illegal
// R10: Bit 6 picks copy for MRW/MRR
// R11: Bit 7 picks operating copy
// R12: Training control at 0D, write-only
// R13: DQ reference at 0E, code 0-50; the code stores op bits 6:0 as written and does not limit the level to 50
// R14: Bit 6 selects range, default one
// R15: Read returns bits on DQ, reserved zero
// R16: Controller writes range with level
// R17: Values held until overwritten or reset
// R18: Reset restores defaults in every copy
//
// Added by the designer: the strobed register port.
`include "dtfm_map.svh"
module dtfm_device
    import dtfm_pkg::*;
(
    input wire logic CLK_SYS_IN,
    input wire logic ARST_N_IN,
    dtfm_if.dev BUS,
    input wire logic CONFIG_RRO_VALID_IN,
    input wire logic [2:0] REFRESH_RAW_IN,
    output logic [2:0] REFRESH_STATUS_OUT,
    output logic READ_PREAMBLE_TRAIN_OUT,
    output logic REF_OUTPUT_EN_OUT,
    output logic REF_FAST_RESPONSE_OUT,
    output logic DATA_MASK_EN_OUT,
    output logic MASKED_WRITE_ERR_OUT,
    output logic [7:0] ACTIVE_DQ_REF_OUT
);
    logic [7:0] train_reg;
    logic [7:0] dq_ref_reg [2];
    logic [7:0] dq_reg;
    logic dq_valid_reg;
    logic [2:0] refresh_next;
    logic wsel;
    logic osel;

    assign wsel = train_reg[`DTFM_BIT_FSPWR];
    assign osel = train_reg[`DTFM_BIT_FSPOP];
    assign BUS.dq = dq_reg;
    assign BUS.dq_valid = dq_valid_reg;

    // While training with CKE low, MRW and MRR commands are not decoded
    function automatic logic cmd_live(input logic command_bus_training_enable, input logic cke);
        cmd_live = !(command_bus_training_enable && !cke);
    endfunction : cmd_live

    // ------------------------------------------------------------
    // Training control register
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
            train_reg <= `DTFM_TRAIN_RESET; // [R18]
        else if (cmd_live(train_reg[`DTFM_BIT_CBT], BUS.cke)
                 && BUS.cmd == DTFM_CMD_MRW
                 && BUS.addr == `DTFM_MA_TRAIN_CTRL)
            train_reg <= BUS.op; // [R12] [R1] [R2]
    end

    // ------------------------------------------------------------
    // DQ reference copies, one per set point
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2; i++)
    begin : g_copy
        always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
        begin
            if (!ARST_N_IN)
                dq_ref_reg[i] <= `DTFM_DQ_REF_RESET; // [R18] [R14]
            else if (cmd_live(train_reg[`DTFM_BIT_CBT], BUS.cke)
                     && BUS.cmd == DTFM_CMD_MRW
                     && BUS.addr == `DTFM_MA_DQ_REF
                     && wsel == i[0])
                // Reserved bit 7 stored as zero; held otherwise
                dq_ref_reg[i] <= {1'b0, BUS.op[6:0]}; // [R10] [R13] [R17]
        end
    end

    // ------------------------------------------------------------
    // DQ return path: reads and training echo
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            dq_reg <= 8'h00;
            dq_valid_reg <= 1'b0;
        end
        else if (!cmd_live(train_reg[`DTFM_BIT_CBT], BUS.cke))
        begin
            dq_reg <= {2'b00, BUS.ca}; // [R1]
            dq_valid_reg <= 1'b1;
        end
        else if (train_reg[`DTFM_BIT_VRO])
        begin
            dq_reg <= dq_ref_reg[osel]; // [R4]
            dq_valid_reg <= 1'b1;
        end
        else if (BUS.cmd == DTFM_CMD_MRR && BUS.addr == `DTFM_MA_DQ_REF)
        begin
            dq_reg <= dq_ref_reg[wsel]; // [R15] [R10]
            dq_valid_reg <= 1'b1;
        end
        else
        begin
            // Write-only control and unmapped addresses read zero
            dq_reg <= 8'h00; // [R12]
            dq_valid_reg <= BUS.cmd == DTFM_CMD_MRR;
        end
    end

    // ------------------------------------------------------------
    // Refresh status filter
    // ------------------------------------------------------------
    always_comb
    begin
        refresh_next = REFRESH_RAW_IN;
        if (CONFIG_RRO_VALID_IN && !train_reg[`DTFM_BIT_RRO]
            && (REFRESH_RAW_IN == `DTFM_REFRESH_LOW1
                || REFRESH_RAW_IN == `DTFM_REFRESH_LOW2))
            refresh_next = `DTFM_REFRESH_FORCED; // [R6] [R7]
    end

    // ------------------------------------------------------------
    // Registered mode outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            REFRESH_STATUS_OUT <= 3'h0;
            READ_PREAMBLE_TRAIN_OUT <= 1'b0;
            REF_OUTPUT_EN_OUT <= 1'b0;
            REF_FAST_RESPONSE_OUT <= 1'b0;
            DATA_MASK_EN_OUT <= 1'b1;
            MASKED_WRITE_ERR_OUT <= 1'b0;
            ACTIVE_DQ_REF_OUT <= `DTFM_DQ_REF_RESET;
        end
        else
        begin
            // Self refresh logic reads the raw code, not this one
            REFRESH_STATUS_OUT <= refresh_next; // [R8]
            READ_PREAMBLE_TRAIN_OUT <= train_reg[`DTFM_BIT_RPT]; // [R3]
            REF_OUTPUT_EN_OUT <= train_reg[`DTFM_BIT_VRO]; // [R4]
            REF_FAST_RESPONSE_OUT <= train_reg[`DTFM_BIT_REFERENCE_FAST_RESPONSE]; // [R5]
            DATA_MASK_EN_OUT <= !train_reg[`DTFM_BIT_DMD]; // [R9]
            MASKED_WRITE_ERR_OUT <= train_reg[`DTFM_BIT_DMD]
                && BUS.cmd == DTFM_CMD_MWM; // [R9]
            ACTIVE_DQ_REF_OUT <= dq_ref_reg[osel]; // [R11]
        end
    end
endmodule : dtfm_device

// ### rtl/dtfm_map.svh
// Mode register addresses, field positions and reset values
`ifndef DTFM_MAP_SVH
`define DTFM_MAP_SVH
`define DTFM_MA_TRAIN_CTRL 6'h0d
`define DTFM_MA_DQ_REF 6'h0e
`define DTFM_BIT_CBT 0
`define DTFM_BIT_RPT 1
`define DTFM_BIT_VRO 2
`define DTFM_BIT_REFERENCE_FAST_RESPONSE 3
`define DTFM_BIT_RRO 4
`define DTFM_BIT_DMD 5
`define DTFM_BIT_FSPWR 6
`define DTFM_BIT_FSPOP 7
`define DTFM_BIT_RANGE 6
`define DTFM_TRAIN_RESET 8'h00
`define DTFM_DQ_REF_RESET 8'h5d
`define DTFM_LEVEL_MAX 6'h32
`define DTFM_REFRESH_FORCED 3'h3
`define DTFM_REFRESH_LOW1 3'h1
`define DTFM_REFRESH_LOW2 3'h2
`define DTFM_HOST_CTRL 4'h0
`define DTFM_HOST_STATUS 4'h1
`define DTFM_HOST_RDATA 4'h2
`endif

// ### rtl/dtfm_pkg.sv
// Types shared by both ends of the mode register link
package dtfm_pkg;
    typedef enum logic [1:0] {
        DTFM_CMD_NONE,
        DTFM_CMD_MRW,
        DTFM_CMD_MRR,
        DTFM_CMD_MWM
    } dtfm_cmd_t;
    typedef enum logic [1:0] {
        DTFM_HS_IDLE,
        DTFM_HS_WAIT,
        DTFM_HS_DONE
    } dtfm_host_state_t;
endpackage : dtfm_pkg

// ### rtl/dtfm_if.sv
// Command bus carrier between controller and DRAM mode registers
interface dtfm_if;
    import dtfm_pkg::*;
    dtfm_cmd_t cmd;
    logic [5:0] addr;
    logic [7:0] op;
    logic cke;
    logic [5:0] ca;
    logic [7:0] dq;
    logic dq_valid;
    modport dev (
        input cmd, addr, op, cke, ca,
        output dq, dq_valid
    );
    modport ctl (
        output cmd, addr, op, cke, ca,
        input dq, dq_valid
    );
endinterface : dtfm_if

// ### rtl/dtfm_controller.sv
// Controller side: issues mode register commands from a register port
`include "dtfm_map.svh"
module dtfm_controller
    import dtfm_pkg::*;
(
    input wire logic CLK_SYS_IN,
    input wire logic ARST_N_IN,
    dtfm_if.ctl BUS,
    input wire logic [3:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [31:0] RDATA_OUT
);
    logic [1:0] cmd_code;
    dtfm_cmd_t cmd_reg;
    logic [5:0] addr_reg;
    logic [7:0] op_reg;
    logic cke_reg;
    logic [5:0] ca_reg;
    logic dmd_reg;
    logic [7:0] rdata_reg;
    logic busy_reg;
    logic err_reg;
    dtfm_host_state_t state_reg;

    assign cmd_code = WDATA_IN[17:16];
    assign BUS.cmd = cmd_reg;
    assign BUS.addr = addr_reg;
    assign BUS.op = op_reg;
    assign BUS.cke = cke_reg;
    assign BUS.ca = ca_reg;

    // ------------------------------------------------------------
    // Command issue: ctrl = {cke[24], ca[23:18], cmd[17:16], ma, op}
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            cmd_reg <= DTFM_CMD_NONE;
            addr_reg <= 6'h00;
            op_reg <= 8'h00;
            cke_reg <= 1'b1;
            ca_reg <= 6'h00;
            dmd_reg <= 1'b0;
            err_reg <= 1'b0;
            state_reg <= DTFM_HS_IDLE;
        end
        else
        begin
            cmd_reg <= DTFM_CMD_NONE;
            case (state_reg)
                DTFM_HS_IDLE:
                    if (WR_IN && ADDR_IN == `DTFM_HOST_CTRL)
                    begin
                        cke_reg <= WDATA_IN[24];
                        ca_reg <= WDATA_IN[23:18];
                        if (cmd_code == 2'h3 && dmd_reg)
                            err_reg <= 1'b1; // [R9]
                        else if (cmd_code != 2'h0)
                        begin
                            cmd_reg <= dtfm_cmd_t'(cmd_code);
                            addr_reg <= WDATA_IN[13:8];
                            // Range always travels with the level
                            op_reg <= WDATA_IN[7:0]; // [R16]
                            // Other commands keep software's CKE level
                            if (cmd_code == 2'h1
                                && WDATA_IN[13:8] == `DTFM_MA_TRAIN_CTRL)
                            begin
                                // Training exit needs CKE high first
                                cke_reg <= 1'b1; // [R2]
                                dmd_reg <= WDATA_IN[`DTFM_BIT_DMD];
                            end
                            state_reg <= DTFM_HS_WAIT;
                        end
                    end
                DTFM_HS_WAIT:
                    state_reg <= DTFM_HS_DONE;
                DTFM_HS_DONE:
                    state_reg <= DTFM_HS_IDLE;
                default:
                    state_reg <= DTFM_HS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Captured read data and busy flag
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            rdata_reg <= 8'h00;
            busy_reg <= 1'b0;
        end
        else
        begin
            busy_reg <= state_reg == DTFM_HS_IDLE ? (WR_IN
                && ADDR_IN == `DTFM_HOST_CTRL && cmd_code != 2'h0)
                : state_reg != DTFM_HS_DONE;
            if (BUS.dq_valid)
                rdata_reg <= BUS.dq;
        end
    end

    // ------------------------------------------------------------
    // Software read port
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
            RDATA_OUT <= 32'h0;
        else if (RD_IN && ADDR_IN == `DTFM_HOST_STATUS)
            RDATA_OUT <= {29'h0, err_reg, dmd_reg, busy_reg};
        else if (RD_IN && ADDR_IN == `DTFM_HOST_RDATA)
            RDATA_OUT <= {24'h0, rdata_reg};
        else
            RDATA_OUT <= 32'h0;
    end
endmodule : dtfm_controller

// ### verif/dtfm_chk.sv
// Concurrent checks on the mode register command link
`include "dtfm_map.svh"
module dtfm_chk
    import dtfm_pkg::*;
(
    input wire logic CLK_SYS_IN,
    input wire logic ARST_N_IN,
    input wire dtfm_cmd_t cmd,
    input wire logic [5:0] addr,
    input wire logic [7:0] op,
    input wire logic cke,
    input wire logic [5:0] ca,
    input wire logic [7:0] dq,
    input wire logic dq_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Shadow of the device registers
    // ------------------------------------------------------------
    logic [7:0] train_reg, ref0_reg, ref1_reg, wsel, act;
    logic blk, mrw, mrr;
    // Training with CKE low swallows MRW and MRR commands
    assign blk = train_reg[0] && !cke;
    assign mrw = cmd == DTFM_CMD_MRW && !blk;
    assign mrr = cmd == DTFM_CMD_MRR && !blk && !train_reg[2];
    assign wsel = train_reg[6] ? ref1_reg : ref0_reg;
    assign act = train_reg[7] ? ref1_reg : ref0_reg;
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
        if (!ARST_N_IN)
            train_reg <= `DTFM_TRAIN_RESET;
        else if (mrw && addr == `DTFM_MA_TRAIN_CTRL)
            train_reg <= op;
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
        if (!ARST_N_IN)
        begin
            ref0_reg <= `DTFM_DQ_REF_RESET;
            ref1_reg <= `DTFM_DQ_REF_RESET;
        end
        else if (mrw && addr == `DTFM_MA_DQ_REF && train_reg[6])
            ref1_reg <= {1'b0, op[6:0]};
        else if (mrw && addr == `DTFM_MA_DQ_REF)
            ref0_reg <= {1'b0, op[6:0]};
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (!ARST_N_IN);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    AST_MRR_REF: assert property (mrr && addr == 6'h0e |=>
        dq_valid && dq == $past(wsel)) else $error("bad reference read");
    AST_MRR_WO: assert property (mrr && addr == 6'h0d |=>
        dq_valid && dq == 8'h00) else $error("write-only read not zero");
    AST_ECHO: assert property (blk && !train_reg[2] |=>
        dq_valid && dq == {2'b00, $past(ca)}) else $error("bad echo");
    AST_VRO: assert property (train_reg[2] && !blk && cmd != DTFM_CMD_MRR
        |=> dq_valid && dq == $past(act))
        else $error("bad reference output");
    AST_QUIET: assert property (cmd != DTFM_CMD_MRR && !blk
        && !train_reg[2] |=> !dq_valid) else $error("stray dq_valid");
    AST_CKE_EXIT: assert property (mrw && addr == 6'h0d &&
        train_reg[0] && !op[0] |-> cke) else $error("exit with cke low");
    AST_NO_MWM: assert property (train_reg[5]
        |-> cmd != DTFM_CMD_MWM) else $error("masked write issued");
    AST_SPACING: assert property (cmd != DTFM_CMD_NONE
        |=> (cmd == DTFM_CMD_NONE) [*2]) else $error("commands too close");
    cover property (mrr && addr == 6'h0e && train_reg[6]);
    cover property (blk ##1 dq_valid);
    cover property (train_reg[7] && !train_reg[6]);
endmodule : dtfm_chk

// ### verif/tb_dram_training_fsp_mode_regs.sv
// Testbench joining controller and device over the command link
module tb_dram_training_fsp_mode_regs
    import dtfm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] op;
        logic vld;
        logic [2:0] raw;
        logic [6:0] exp;
    } dtfm_row_t;
    // Expected {preamble, vref out, fast, mask on, refresh status}
    dtfm_row_t rows [8] = '{'{8'h02, 1'b0, 3'h1, 7'h49},
        '{8'h04, 1'b1, 3'h2, 7'h2b}, '{8'h08, 1'b1, 3'h1, 7'h1b},
        '{8'h10, 1'b1, 3'h1, 7'h09}, '{8'h20, 1'b1, 3'h2, 7'h03},
        '{8'h30, 1'b1, 3'h2, 7'h02}, '{8'h00, 1'b1, 3'h5, 7'h0d},
        '{8'h00, 1'b0, 3'h2, 7'h0a}};
    logic clk_sys = 1'b0, arst_n = 1'b0, h_wr = 1'b0, h_rd = 1'b0;
    logic rro_vld = 1'b0, read_preamble_training_enable, reference_voltage_output, fast, dm_en, mwe;
    logic [3:0] h_addr = 4'h0;
    logic [31:0] h_wdata = 32'h0, h_rdata;
    logic [2:0] raw = 3'h0, status;
    logic [7:0] act_ref;
    int err_count = 0, checked = 0;
    dtfm_if i_dtfm_if ();
    dtfm_device i_dtfm_device (.CLK_SYS_IN(clk_sys), .ARST_N_IN(arst_n),
        .BUS(i_dtfm_if), .CONFIG_RRO_VALID_IN(rro_vld),
        .REFRESH_RAW_IN(raw), .REFRESH_STATUS_OUT(status),
        .READ_PREAMBLE_TRAIN_OUT(read_preamble_training_enable), .REF_OUTPUT_EN_OUT(reference_voltage_output),
        .REF_FAST_RESPONSE_OUT(fast), .DATA_MASK_EN_OUT(dm_en),
        .MASKED_WRITE_ERR_OUT(mwe), .ACTIVE_DQ_REF_OUT(act_ref));
    dtfm_controller i_dtfm_controller (.CLK_SYS_IN(clk_sys),
        .ARST_N_IN(arst_n), .BUS(i_dtfm_if), .ADDR_IN(h_addr),
        .WDATA_IN(h_wdata), .WR_IN(h_wr), .RD_IN(h_rd), .RDATA_OUT(h_rdata));
    dtfm_chk i_dtfm_chk (.CLK_SYS_IN(clk_sys), .ARST_N_IN(arst_n),
        .cmd(i_dtfm_if.cmd), .addr(i_dtfm_if.addr), .op(i_dtfm_if.op),
        .cke(i_dtfm_if.cke), .ca(i_dtfm_if.ca), .dq(i_dtfm_if.dq),
        .dq_valid(i_dtfm_if.dq_valid));
    // ------------------------------------------------------------
    // Host port tasks
    // ------------------------------------------------------------
    task give_verdict;
        if (err_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Waits past the busy window before the next command
    task cmdw(input logic [31:0] d);
        @(posedge clk_sys);
        h_addr <= 4'h0;
        h_wdata <= d;
        h_wr <= 1'b1;
        @(posedge clk_sys);
        h_wr <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask : cmdw
    task rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        h_addr <= a;
        h_rd <= 1'b1;
        @(posedge clk_sys);
        h_rd <= 1'b0;
        #1 chk(h_rdata, e);
    endtask : rd
    task mrr(input logic [5:0] ma, input logic [7:0] e);
        cmdw({18'h00408, ma, 8'h00});
        rd(4'h2, {24'h0, e});
    endtask : mrr
    task do_reset;
        @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        chk({act_ref, 7'h0, dm_en}, 16'h5d01);
        mrr(6'h0e, 8'h5d);
    endtask : do_reset
    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        err_count++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        do_reset();
        foreach (rows[i])
        begin
            rro_vld <= rows[i].vld;
            raw <= rows[i].raw;
            cmdw({24'h01010d, rows[i].op});
            chk({read_preamble_training_enable, reference_voltage_output, fast, dm_en, status}, rows[i].exp);
        end
        mrr(6'h0d, 8'h00);
        cmdw(32'h0101_0d40);
        cmdw(32'h0101_0eff);
        chk(act_ref, 8'h5d);
        mrr(6'h0e, 8'h7f);
        cmdw(32'h0101_0d80);
        chk(act_ref, 8'h7f);
        mrr(6'h0e, 8'h5d);
        cmdw(32'h0101_0e32);
        chk(act_ref, 8'h7f);
        cmdw(32'h0101_0d01);
        cmdw(32'h00a8_0000);
        rd(4'h2, 32'h2a);
        cmdw(32'h0001_0e11);
        cmdw(32'h0100_0000);
        cmdw(32'h0101_0d00);
        chk(act_ref, 8'h32);
        mrr(6'h0e, 8'h32);
        cmdw(32'h0101_0d20);
        cmdw(32'h0103_0000);
        rd(4'h1, 32'h6);
        chk({31'h0, mwe}, 32'h0);
        do_reset();
        give_verdict();
    end
endmodule : tb_dram_training_fsp_mode_regs
